/* File: design/fqsm_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the fault qualify block
`ifndef FQSM_CFG_SVH
`define FQSM_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FQSM_ADDR_W 8
`define FQSM_OFS_FAULT_COUNT_CFG 8'h08
`define FQSM_OFS_SCAN_SEQ_CFG 8'h09
`define FQSM_OFS_FAULT_SIGNAL_MASK 8'h0A
`define FQSM_OFS_GENERAL_DIAGNOSIS 8'h0B

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FQSM_RST_FAULT_COUNT_CFG 16'h0002
`define FQSM_RST_SCAN_SEQ_CFG 16'h8024
`define FQSM_RST_FAULT_SIGNAL_MASK 16'h3400
`define FQSM_RST_GENERAL_DIAGNOSIS 16'h0000

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define FQSM_NFAULT 10
`define FQSM_CNT_W 3
`define FQSM_PERIOD_W 7
`define FQSM_BIT_SEQ_SYNC 7
`define FQSM_BIT_ERR_PIN_SEL 5
`define FQSM_FAULT_LSB 6
`define FQSM_STATUS_W 4
`define FQSM_FAULT_COUNT_MASK 16'h0007
`define FQSM_SCAN_SEQ_MASK 16'hFFFF
`define FQSM_SIGNAL_MASK_MASK 16'hFFE0
`define FQSM_IDX_INT_CHECK 2
`define FQSM_IDX_REG_CRC 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define FQSM_CLK_MHZ 250
`define FQSM_SCAN_LSB_US 1350
`define FQSM_SCAN_LSB_CYCLES (`FQSM_SCAN_LSB_US * `FQSM_CLK_MHZ)
`define FQSM_PRESC_W 20

`endif

/* File: design/fqsm_pkg.sv */
// Types of the fault qualify and signal mask block
package fqsm_pkg;

  typedef struct packed {
    logic [2:0] count;
    logic valid;
  } fqsm_qual_state_t;

  typedef enum logic [0:0] {
    FQSM_SEQ_IDLE,
    FQSM_SEQ_RUN
  } fqsm_seq_mode_t;

  typedef struct packed {
    fqsm_seq_mode_t mode;
    logic [19:0] presc;
    logic [6:0] step;
    logic start;
  } fqsm_seq_state_t;

  typedef struct packed {
    logic [15:0] count_cfg;
    logic [15:0] scan_cfg;
    logic [15:0] signal_mask;
    logic [15:0] diag;
    logic [15:0] rdata;
    logic rvalid;
    logic fault_pin;
    logic emergency;
  } fqsm_top_state_t;

endpackage : fqsm_pkg

/* File: design/fqsm_qualifier.sv */
// Consecutive-detection qualifier for one fault type
`timescale 1ns/1ns
`default_nettype none
`include "fqsm_cfg.svh"

module fqsm_qualifier (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Detection
  input wire logic det_strobe,
  input wire logic det_fault,
  input wire logic count_bypass,
  input wire logic [2:0] consecutive_fault_count,
  // Result
  output logic fault_valid
);

  fqsm_pkg::fqsm_qual_state_t st_reg;
  fqsm_pkg::fqsm_qual_state_t st_next;
  logic [2:0] run;

  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    run = (st_reg.count == 3'h7) ? 3'h7 : 3'(st_reg.count + 3'h1);
    if (det_strobe) begin
      if (det_fault) begin
        st_next.count = run;
        // Zero or one demanded means the first detection qualifies
        st_next.valid = count_bypass || (run >= consecutive_fault_count);
      end else begin
        // A clean measurement breaks the run
        st_next.count = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign fault_valid = st_reg.valid;

endmodule : fqsm_qualifier
`default_nettype wire

/* File: design/fqsm_scan_timer.sv */
// Scan start interval timer with watchdog-write restart
`timescale 1ns/1ns
`default_nettype none
`include "fqsm_cfg.svh"

module fqsm_scan_timer #(
  parameter logic [19:0] LSB_CYCLES = 20'(`FQSM_SCAN_LSB_CYCLES)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic [6:0] sequencer_period,
  input wire logic restart,
  // Result
  output logic scan_start
);

  fqsm_pkg::fqsm_seq_state_t st_reg;
  fqsm_pkg::fqsm_seq_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    case (st_reg.mode)
      fqsm_pkg::FQSM_SEQ_IDLE: begin
        st_next.mode = fqsm_pkg::FQSM_SEQ_RUN;
        st_next.start = 1'b1;
      end
      default: begin
        if (st_reg.presc >= LSB_CYCLES - 20'h1) begin
          st_next.presc = 20'h0;
          if (st_reg.step >= sequencer_period) begin
            st_next.step = 7'h0;
            st_next.start = 1'b1;
          end else begin
            st_next.step = 7'(st_reg.step + 7'h1);
          end
        end else begin
          st_next.presc = 20'(st_reg.presc + 20'h1);
        end
      end
    endcase
    // Restart drops any partial interval so the scan follows the write at once
    if (restart) begin
      st_next.mode = fqsm_pkg::FQSM_SEQ_RUN;
      st_next.presc = 20'h0;
      st_next.step = 7'h0;
      st_next.start = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign scan_start = st_reg.start;

endmodule : fqsm_scan_timer
`default_nettype wire

/* File: design/fqsm_top.sv */
// Fault qualification, scan sequencer config and fault signalling register bank
//
// Contract
// - Overvoltage bypass bit 13 clear counts detections; set validates on first.
// - Undervoltage bypass bit 12 defaults zero; set validates on first detection.
// - Bit 11 bypasses counting for internal overtemperature; resets to zero.
// - Bit 10 bypasses counting for external temperature; resets to zero.
// - Bit 9 set validates open load on first detection; zero counts.
// - Bit 8 set validates converter mismatch at once; zero needs configured count.
// - Sync bit 7 set: watchdog write starts or restarts the scan sequencer.
// - Period field 6:0 sets scan interval; reset value 0x24.
// - Signal mask bit 15 enables signalling balancing overcurrent; reset zero.
// - Signal mask bit 14 enables signalling balancing undercurrent; reset zero.
// - Signal mask bit 13 defaults one, signals cell overvoltage.
// - Signal mask bit 12 defaults one, signals cell undervoltage.
// - Signal mask bit 11 gates internal overtemperature signalling; reset zero.
// - Signal mask bit 10 defaults one, signals external temperature faults.
// - Signal mask bit 9 enables checksum fault signalling; reset zero.
// - Signal mask bit 8 enables internal check fault signalling; reset zero.
// - Bits 7 and 6 enable open load and mismatch signalling; reset zero.
// - Pin select zero: pin inactive, emergency link signal used instead.
// - Pin select one: pin only, held high until watchdog expiry or clear.
// - Signal mask at 0x0A, reset 0x3400, bits 4:0 read zero, retained.
// - General diagnosis at 0x0B, reset 0x0000, retained in sleep.
// - Any set bypass bit validates its fault on the first detection.
// - Counted faults valid after configured consecutive detections, 3-bit field, default 2.
// - Checksum and internal check faults always validate on detection.
`timescale 1ns/1ns
`default_nettype none
`include "fqsm_cfg.svh"

module fqsm_top #(
  parameter logic [19:0] SCAN_LSB_CYCLES = 20'(`FQSM_SCAN_LSB_CYCLES)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register access from the link
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Watchdog
  input wire logic watchdog_write,
  input wire logic watchdog_expired,
  // Fault detection, index i maps to diagnosis bit i+6
  input wire logic [9:0] det_strobe,
  input wire logic [9:0] det_fault,
  input wire logic [3:0] status_in,
  // Outputs
  output logic scan_start,
  output logic fault_pin,
  output logic emergency_link_signal
);

  fqsm_pkg::fqsm_top_state_t st_reg;
  fqsm_pkg::fqsm_top_state_t st_next;
  logic [9:0] fault_valid;
  logic [9:0] bypass;
  logic scan_start_w;
  logic sig_event;
  logic diag_clear;
  logic [15:0] diag_set;

  // ----------------------------------------
  // Bypass lookup per fault index
  // ----------------------------------------
  function automatic logic bypass_of(input logic [15:0] cfg, input int idx);
    logic b;
    b = 1'b0;
    case (idx)
      0: b = cfg[8];
      1: b = cfg[9];
      4: b = cfg[10];
      5: b = cfg[11];
      6: b = cfg[12];
      7: b = cfg[13];
      8: b = cfg[14];
      9: b = cfg[15];
      default: b = 1'b1;
    endcase
    return b;
  endfunction : bypass_of

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : is_reg

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `FQSM_NFAULT; gi++) begin : g_qual
      assign bypass[gi] = bypass_of(st_reg.scan_cfg, gi);
      fqsm_qualifier u_qual (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .det_strobe(det_strobe[gi]),
        .det_fault(det_fault[gi]),
        .count_bypass(bypass[gi]),
        .consecutive_fault_count(st_reg.count_cfg[2:0]),
        .fault_valid(fault_valid[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  fqsm_scan_timer #(
    .LSB_CYCLES(SCAN_LSB_CYCLES)
  ) u_scan (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .sequencer_period(st_reg.scan_cfg[6:0]),
    .restart(watchdog_write && st_reg.scan_cfg[`FQSM_BIT_SEQ_SYNC]),
    .scan_start(scan_start_w)
  );

  // ----------------------------------------
  // Register bank and signalling
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    diag_set = {fault_valid, 6'h00};
    diag_clear = 1'b0;
    // Masked fault types only; a new valid detection triggers signalling
    sig_event = |(diag_set & st_reg.signal_mask & 16'hFFC0);
    if (reg_wr) begin
      if (is_reg(reg_addr, `FQSM_OFS_FAULT_COUNT_CFG)) begin
        st_next.count_cfg = reg_wdata & `FQSM_FAULT_COUNT_MASK;
      end else if (is_reg(reg_addr, `FQSM_OFS_SCAN_SEQ_CFG)) begin
        st_next.scan_cfg = reg_wdata & `FQSM_SCAN_SEQ_MASK;
      end else if (is_reg(reg_addr, `FQSM_OFS_FAULT_SIGNAL_MASK)) begin
        st_next.signal_mask = reg_wdata & `FQSM_SIGNAL_MASK_MASK;
      end else if (is_reg(reg_addr, `FQSM_OFS_GENERAL_DIAGNOSIS)) begin
        // Writing zero to a fault bit clears it
        st_next.diag = st_reg.diag & reg_wdata & 16'hFFC0;
        diag_clear = 1'b1;
      end
    end
    // New detections win over a clearing write in the same cycle
    st_next.diag = (st_next.diag | diag_set) & 16'hFFC0;
    // Pin select is bit 5 of the signal mask register
    if (st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL]) begin
      // Pin holds until watchdog runs out or diagnosis is written
      st_next.fault_pin = sig_event || (st_reg.fault_pin && !watchdog_expired && !diag_clear);
      st_next.emergency = 1'b0;
    end else begin
      st_next.fault_pin = 1'b0;
      st_next.emergency = sig_event;
    end
    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      if (is_reg(reg_addr, `FQSM_OFS_FAULT_COUNT_CFG)) begin
        st_next.rdata = st_reg.count_cfg;
      end else if (is_reg(reg_addr, `FQSM_OFS_SCAN_SEQ_CFG)) begin
        st_next.rdata = st_reg.scan_cfg;
      end else if (is_reg(reg_addr, `FQSM_OFS_FAULT_SIGNAL_MASK)) begin
        st_next.rdata = st_reg.signal_mask;
      end else if (is_reg(reg_addr, `FQSM_OFS_GENERAL_DIAGNOSIS)) begin
        st_next.rdata = st_reg.diag | {12'h000, status_in};
      end else begin
        st_next.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg.count_cfg <= `FQSM_RST_FAULT_COUNT_CFG;
      st_reg.scan_cfg <= `FQSM_RST_SCAN_SEQ_CFG;
      st_reg.signal_mask <= `FQSM_RST_FAULT_SIGNAL_MASK;
      st_reg.diag <= `FQSM_RST_GENERAL_DIAGNOSIS;
      st_reg.rdata <= 16'h0000;
      st_reg.rvalid <= 1'b0;
      st_reg.fault_pin <= 1'b0;
      st_reg.emergency <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Scan start is already a flip-flop inside the timer
  assign scan_start = scan_start_w;
  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign fault_pin = st_reg.fault_pin;
  assign emergency_link_signal = st_reg.emergency;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_first_hit(int i);
    ce && det_strobe[i] && det_fault[i];
  endsequence

  sequence s_clean(int i);
    ce && det_strobe[i] && !det_fault[i];
  endsequence

  a_ov_bypass_first: assert property (
    (s_first_hit(7) and bypass[7]) |=> fault_valid[7])
    else $error("overvoltage bypass did not validate first detection");

  // Run length is read inside the qualifier, so any strobe spacing is covered
  a_uv_count_holds: assert property (
    (s_first_hit(6) ##0 (!bypass[6] && st_reg.count_cfg[2:0] >= 3'h2
     && g_qual[6].u_qual.st_reg.count == 3'h0)) |=> !fault_valid[6])
    else $error("undervoltage validated before count reached");

  a_clean_resets_run: assert property (
    s_clean(1) |=> (g_qual[1].u_qual.st_reg.count == 3'h0))
    else $error("clean measurement left the detection run standing");

  a_count_two_hits: assert property (
    (s_first_hit(0) ##0 (!bypass[0] && st_reg.count_cfg[2:0] >= 3'h2
     && g_qual[0].u_qual.st_reg.count == 3'(st_reg.count_cfg[2:0] - 3'h1))) |=> fault_valid[0])
    else $error("mismatch fault not valid after configured consecutive detections");

  a_crc_no_counter: assert property (
    s_first_hit(`FQSM_IDX_REG_CRC) |=> fault_valid[`FQSM_IDX_REG_CRC])
    else $error("checksum fault was counted");

  a_sync_restart: assert property (
    (ce && watchdog_write && st_reg.scan_cfg[`FQSM_BIT_SEQ_SYNC]) |=> scan_start)
    else $error("watchdog write with sync did not start scan");

  a_emm_when_unpinned: assert property (
    (ce && sig_event && !st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL]) |=> emergency_link_signal && !fault_pin)
    else $error("emergency signal missing with pin deselected");

  a_pin_only: assert property (
    st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL] |-> !emergency_link_signal
    || $past(!st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL]))
    else $error("emergency signal sent while pin selected");

  a_pin_holds: assert property (
    (fault_pin && ce && st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL] && !watchdog_expired && !diag_clear)
    |=> fault_pin)
    else $error("fault pin dropped without clear");

  a_mask_gates: assert property (
    (ce && fault_valid[7] && !st_reg.signal_mask[13] && !(|(diag_set & st_reg.signal_mask)))
    |=> !emergency_link_signal)
    else $error("masked overvoltage raised signalling");

  a_mask_reserved: assert property (
    ##1 (st_reg.signal_mask[4:0] == 5'h00))
    else $error("reserved signal mask bits not zero");

  a_diag_sticky: assert property (
    (ce && fault_valid[9]) |=> st_reg.diag[15])
    else $error("diagnosis bit lost on set");

  // ----------------------------------------
  // Signalling, qualifier and register port checks
  // ----------------------------------------
  // Masks meet the raw valid pulses here, so a shifted diagnosis map shows up
  a_masked_silent: assert property (
    (ce && !(|(fault_valid & st_reg.signal_mask[15:6]))) |=> !emergency_link_signal)
    else $error("masked fault types raised the emergency signal");

  a_unpinned_pin_low: assert property (
    (ce && !st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL]) |=> !fault_pin)
    else $error("fault pin driven with pin deselected");

  a_pin_expiry: assert property (
    (ce && st_reg.signal_mask[`FQSM_BIT_ERR_PIN_SEL] && watchdog_expired
     && !(|(fault_valid & st_reg.signal_mask[15:6]))) |=> !fault_pin)
    else $error("fault pin stayed high after watchdog expiry");

  a_uv_bypass_first: assert property (
    (s_first_hit(6) and bypass[6]) |=> fault_valid[6])
    else $error("undervoltage bypass did not validate first detection");

  a_icheck_no_counter: assert property (
    s_first_hit(`FQSM_IDX_INT_CHECK) |=> fault_valid[`FQSM_IDX_INT_CHECK])
    else $error("internal check fault was counted");

  a_read_answer: assert property (
    (ce && reg_rd) |=> reg_rvalid)
    else $error("read not answered in the next cycle");

  a_rvalid_only_read: assert property (
    (ce && !reg_rd) |=> !reg_rvalid)
    else $error("read valid without a read");

  a_reserved_read: assert property (
    (ce && reg_rd && reg_addr == `FQSM_OFS_FAULT_SIGNAL_MASK) |=> (reg_rdata[4:0] == 5'h00))
    else $error("reserved signal mask bits read nonzero");

endmodule : fqsm_top
`default_nettype wire

/* File: verif/fqsm_host_model.sv */
// Host controller model issuing register accesses over the link
`timescale 1ns/1ns
`default_nettype none

module fqsm_host_model (
  // Clock
  input wire logic clk_sys,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  // Idle lines flip so a stale address or data never passes for a live one
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : release_bus

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    release_bus();
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic valid);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    release_bus();
    data = reg_rdata;
    valid = reg_rvalid;
  endtask : rd
endmodule : fqsm_host_model
`default_nettype wire

/* File: verif/fault_qualify_and_signal_mask_tb.sv */
// Self-checking testbench of the fault qualify and signal mask block
`timescale 1ns/1ns
`default_nettype none

module fault_qualify_and_signal_mask_tb;
  localparam int TD = 1;
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, watchdog_write, watchdog_expired;
  logic scan_start, fault_pin, emergency_link_signal, rv, f;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rdat, smask, scfg;
  logic [9:0] det_strobe, det_fault;
  logic [3:0] status_in;
  int seed = 32'h82464f14;
  int err_count, cmp_count, n, cnt, lim;

  fqsm_top #(.SCAN_LSB_CYCLES(20'h00004)) i_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .watchdog_write(watchdog_write),
    .watchdog_expired(watchdog_expired), .det_strobe(det_strobe), .det_fault(det_fault),
    .status_in(status_in), .scan_start(scan_start), .fault_pin(fault_pin),
    .emergency_link_signal(emergency_link_signal));

  fqsm_host_model i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Checks and expectations
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Two fault types never pass through the counter
  function automatic logic qual_byp(input int i, input logic [15:0] cfg);
    if (i == 2 || i == 3) begin
      return 1'b1;
    end
    return (i >= 4) ? cfg[i + 6] : cfg[i + 8];
  endfunction : qual_byp

  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
    i_host.rd(addr, rdat, rv);
    chk($sformatf("read valid %h", addr), 16'h0001, {15'h0000, rv});
    chk($sformatf("read data %h", addr), exp, rdat);
  endtask : rd_chk

  // Valid is registered in the qualifier, signalling once more: look after the next edge
  task automatic detect(input int i, input logic flt, input logic exp_emg, input logic exp_pin);
    @(posedge clk_sys);
    #TD;
    det_strobe[i] = 1'b1;
    det_fault[i] = flt;
    @(posedge clk_sys);
    #TD;
    det_strobe[i] = 1'b0;
    det_fault = 10'($random(seed));
    @(posedge clk_sys);
    #TD;
    chk("emergency", {15'h0000, exp_emg}, {15'h0000, emergency_link_signal});
    chk("fault pin", {15'h0000, exp_pin}, {15'h0000, fault_pin});
  endtask : detect

  task automatic wait_scan(input int lim_cyc);
    n = 0;
    do begin
      @(posedge clk_sys);
      #TD;
      n++;
    end while (scan_start !== 1'b1 && n < lim_cyc);
  endtask : wait_scan

  task automatic wd_pulse();
    watchdog_write = 1'b1;
    @(posedge clk_sys);
    #TD;
    watchdog_write = 1'b0;
  endtask : wd_pulse

  initial begin
    #100000;
    err_count++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    watchdog_write = 1'b0;
    watchdog_expired = 1'b0;
    det_strobe = 10'h000;
    det_fault = 10'h000;
    status_in = 4'($random(seed));
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_sys);
    #TD;
    rst = 1'b0;
    rd_chk(8'h08, 16'h0002);
    rd_chk(8'h09, 16'h8024);
    rd_chk(8'h0A, 16'h3400);
    rd_chk(8'h0B, {12'h000, status_in});
    rd_chk(8'h3C, 16'h0000);
    scfg = 16'($random(seed));
    i_host.wr(8'h0A, scfg);
    rd_chk(8'h0A, scfg & 16'hFFE0);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 10; i++) begin
        lim = 2 + (($random(seed) & 32'h7FFFFFFF) % 3);
        scfg = {8'($random(seed)), 8'h24};
        smask = {10'($random(seed)), 6'h00};
        i_host.wr(8'h08, 16'(lim));
        i_host.wr(8'h09, scfg);
        i_host.wr(8'h0A, smask);
        i_host.wr(8'h0B, 16'h0000);
        // A clean measurement first drops any run left by an earlier scenario
        detect(i, 1'b0, 1'b0, 1'b0);
        cnt = 0;
        // One clean measurement splits the run of detections
        for (int k = 0; k < 2 * lim; k++) begin
          f = (k != lim - 1);
          cnt = f ? cnt + 1 : 0;
          detect(i, f, f & smask[i + 6] & (qual_byp(i, scfg) | (cnt >= lim)), 1'b0);
        end
        rd_chk(8'h0B, 16'(1 << (i + 6)) | {12'h000, status_in});
      end
    end
    i_host.wr(8'h0A, 16'hFFE0);
    detect(3, 1'b1, 1'b0, 1'b1);
    repeat (5) @(posedge clk_sys);
    #TD;
    chk("fault pin held", 16'h0001, {15'h0000, fault_pin});
    watchdog_expired = 1'b1;
    @(posedge clk_sys);
    #TD;
    watchdog_expired = 1'b0;
    @(posedge clk_sys);
    #TD;
    chk("fault pin after expiry", 16'h0000, {15'h0000, fault_pin});
    detect(2, 1'b1, 1'b0, 1'b1);
    i_host.wr(8'h0B, 16'h0000);
    @(posedge clk_sys);
    #TD;
    chk("fault pin after clear", 16'h0000, {15'h0000, fault_pin});
    i_host.wr(8'h09, 16'h0082);
    for (int k = 0; k < 2; k++) begin
      repeat (5) @(posedge clk_sys);
      #TD;
      wd_pulse();
      chk("scan on watchdog write", 16'h0001, {15'h0000, scan_start});
      wait_scan(600);
      chk("scan interval", 16'h000C, 16'(n));
    end
    i_host.wr(8'h09, 16'h007F);
    wait_scan(600);
    wd_pulse();
    chk("scan without sync", 16'h0000, {15'h0000, scan_start});
    wait_scan(600);
    chk("longest scan interval", 16'h01FF, 16'(n));
    end_sim();
  end
endmodule : fault_qualify_and_signal_mask_tb
`default_nettype wire
